//--- gsb_consts.svh
// constants for the gateway status byte generator
`ifndef GSB_CONSTS_SVH
`define GSB_CONSTS_SVH

`define GSB_CLK_PERIOD_NS  8
`define GSB_FLASH_HALF_NS  250000000
`define GSB_RING_BYTES     11'h400
`define GSB_BIT_WACK       3'h0
`define GSB_BIT_SERVICE    3'h2
`define GSB_BIT_PENDING    3'h3
`define GSB_BIT_BLOCK      3'h4
`define GSB_BIT_LOSS       3'h5
`define GSB_BIT_OVERFLOW   3'h6
`define GSB_BIT_FRESH      3'h7
`define GSB_STATUS_RESET   8'h00
`define GSB_LENGTH_RESET   8'h00

`endif

//--- gsb_pkg.sv
// types shared by the gateway status byte generator
package gsb_pkg;

  // service switch position, as read from the two switch contacts
  typedef enum logic [1:0] {
    SW_NORMAL,
    SW_GATEWAY_SERVICE,
    SW_ENDPOINT_SERVICE,
    SW_UNUSED
  } gsb_switch_type;

  typedef enum logic {
    MODE_TRANSPARENT,
    MODE_COLLECTIVE
  } gsb_mode_type;

  // one-cycle event pulses from the surrounding gateway logic
  typedef struct packed {
    logic copy_done;
    logic send_done;
    logic block_moved;
    logic set_sent;
    logic discard;
    logic ring_write;
  } gsb_event_type;

endpackage

//--- gsb_led_flasher.sv
// power led driver: steady on, flashing while flash_en is high
`timescale 1ns/1ps
`include "gsb_consts.svh"
module gsb_led_flasher #(
  parameter int unsigned HALF_CYC = `GSB_FLASH_HALF_NS / `GSB_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // control
  input  wire logic flash_en,
  // led
  output logic      led_r
);

  logic [31:0] half_cnt_r;
  logic        half_tick;

  assign half_tick = (half_cnt_r == 32'(HALF_CYC - 1));

  always_ff @(posedge sys_clk) begin
    if (reset || !flash_en || half_tick) begin
      half_cnt_r <= 32'h0000_0000;
    end else begin
      half_cnt_r <= half_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || !flash_en) begin
      led_r <= 1'b1;
    end else if (half_tick) begin
      led_r <= ~led_r;
    end
  end

endmodule

//--- gsb_status_bytes.sv
// status byte generator: two input status bytes sent to the plc
`timescale 1ns/1ps
`include "gsb_consts.svh"
module gsb_status_bytes
  import gsb_pkg::*;
#(
  parameter int unsigned FLASH_HALF_CYC = `GSB_FLASH_HALF_NS / `GSB_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          reset,
  // service switch contacts (pins)
  input  wire logic [1:0]    service_switch,
  // configuration and buffer levels from gateway logic
  input  wire gsb_mode_type  gateway_mode,
  input  wire logic [7:0]    input_data_len,
  input  wire logic [10:0]   tx_buffer_fill,
  input  wire logic [10:0]   ring_fill,
  // events and the length of the data set being delivered
  input  wire gsb_event_type events,
  input  wire logic [15:0]   message_len,
  // status bytes toward the plc
  output logic [7:0]         status_byte0_r,
  output logic [7:0]         payload_length_r,
  // front panel and serial handshake
  output logic               power_led,
  output logic               serial_rts_r
);

  logic [1:0]     sw_meta_r;
  logic [1:0]     sw_sync_r;
  gsb_switch_type switch_pos;
  logic           collective;
  logic           oversize;
  logic [7:0]     length_nxt;

  logic write_ack_r;
  logic service_active_flag_r;
  logic tx_data_pending_r;
  logic block_ready_toggle_r;
  logic data_loss_flag_r;
  logic overflow_r;
  logic fresh_data_toggle_r;

  // two-stage synchroniser for the switch pins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sw_meta_r <= 2'h0;
      sw_sync_r <= 2'h0;
    end else begin
      sw_meta_r <= service_switch;
      sw_sync_r <= sw_meta_r;
    end
  end

  assign switch_pos = gsb_switch_type'(sw_sync_r);
  assign collective = (gateway_mode == MODE_COLLECTIVE);
  assign oversize   = (message_len > {8'h00, input_data_len});

  // length of the data set actually forwarded
  always_comb begin
    if (oversize) begin
      length_nxt = input_data_len;
    end else begin
      length_nxt = message_len[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      write_ack_r <= 1'b0;
    end else if (events.copy_done || events.send_done) begin
      write_ack_r <= ~write_ack_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      service_active_flag_r <= 1'b0;
    end else begin
      service_active_flag_r <= (switch_pos == SW_GATEWAY_SERVICE) ||
                               (switch_pos == SW_ENDPOINT_SERVICE);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_data_pending_r <= 1'b0;
    end else begin
      tx_data_pending_r <= collective && (tx_buffer_fill != 11'h000);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      block_ready_toggle_r <= 1'b0;
    end else if (collective && events.block_moved) begin
      block_ready_toggle_r <= ~block_ready_toggle_r;
    end
  end

  // only a reset clears the loss flag
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      data_loss_flag_r <= 1'b0;
    end else if (events.discard) begin
      data_loss_flag_r <= 1'b1;
    end else if ((events.set_sent || (collective && events.block_moved)) && oversize) begin
      data_loss_flag_r <= 1'b1;
    end
  end

  // a write into a full buffer overflows; set wins over the clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      overflow_r <= 1'b0;
    end else if (events.ring_write && (ring_fill >= `GSB_RING_BYTES)) begin
      overflow_r <= 1'b1;
    end else if (ring_fill < `GSB_RING_BYTES) begin
      overflow_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fresh_data_toggle_r <= 1'b0;
    end else if (!collective && events.set_sent) begin
      fresh_data_toggle_r <= ~fresh_data_toggle_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      payload_length_r <= `GSB_LENGTH_RESET;
    end else if (events.set_sent || (collective && events.block_moved)) begin
      payload_length_r <= length_nxt;
    end
  end

  // output register for status byte 0
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status_byte0_r <= `GSB_STATUS_RESET;
    end else begin
      status_byte0_r <= {fresh_data_toggle_r, overflow_r, data_loss_flag_r,
                         block_ready_toggle_r, tx_data_pending_r,
                         service_active_flag_r, 1'b0, write_ack_r};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      serial_rts_r <= 1'b1;
    end else begin
      serial_rts_r <= !overflow_r;
    end
  end

  gsb_led_flasher #(
    .HALF_CYC (FLASH_HALF_CYC)
  ) u_led (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .flash_en (service_active_flag_r),
    .led_r    (power_led)
  );

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_wack_event;
    events.copy_done || events.send_done;
  endsequence

  sequence s_oversize_send;
    events.set_sent && oversize;
  endsequence

  property p_wack_toggle;
    s_wack_event |=> (write_ack_r != $past(write_ack_r)) ##1
                     (status_byte0_r[`GSB_BIT_WACK] == $past(write_ack_r));
  endproperty
  a_wack_toggle: assert property (p_wack_toggle)
    else $error("write ack did not toggle");

  property p_service;
    (switch_pos != SW_NORMAL && switch_pos != SW_UNUSED) |=>
      service_active_flag_r ##1 status_byte0_r[`GSB_BIT_SERVICE];
  endproperty
  a_service: assert property (p_service)
    else $error("service bit not set in service position");

  property p_normal;
    (switch_pos == SW_NORMAL) |=> !service_active_flag_r;
  endproperty
  a_normal: assert property (p_normal)
    else $error("service bit not cleared in normal position");

  property p_pending;
    (collective && tx_buffer_fill != 11'h000) |=> tx_data_pending_r ##1
      status_byte0_r[`GSB_BIT_PENDING];
  endproperty
  a_pending: assert property (p_pending)
    else $error("pending bit missing with buffered data");

  property p_block;
    (collective && events.block_moved) |=> $changed(block_ready_toggle_r);
  endproperty
  a_block: assert property (p_block)
    else $error("block ready did not toggle");

  property p_loss_sticky;
    data_loss_flag_r |=> data_loss_flag_r;
  endproperty
  a_loss_sticky: assert property (p_loss_sticky)
    else $error("data loss cleared without reset");

  property p_truncate;
    s_oversize_send |=> data_loss_flag_r && (payload_length_r == $past(input_data_len));
  endproperty
  a_truncate: assert property (p_truncate)
    else $error("oversize message not truncated");

  property p_fresh;
    events.set_sent |=> (fresh_data_toggle_r != $past(fresh_data_toggle_r)) ==
                        !$past(collective);
  endproperty
  a_fresh: assert property (p_fresh)
    else $error("new data toggle wrong for mode");

  property p_rts;
    (events.ring_write && ring_fill >= `GSB_RING_BYTES) |=> overflow_r ##1 !serial_rts_r;
  endproperty
  a_rts: assert property (p_rts)
    else $error("rts still active on overflow");

  property p_reset_zero;
    disable iff (1'b0) reset |=> (status_byte0_r == 8'h00) && (payload_length_r == 8'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("status not zero after reset");

endmodule

//--- gsb_plc_model.sv
// plc side model: polls both status bytes every cycle like a fieldbus master
`timescale 1ns/1ps
module gsb_plc_model (
  // clock
  input  wire logic       sys_clk,
  // status bytes from the gateway
  input  wire logic [7:0] status_byte,
  input  wire logic [7:0] length_byte,
  // last input telegram seen
  output logic [7:0]      seen_status,
  output logic [7:0]      seen_length
);
  always_ff @(posedge sys_clk) begin
    seen_status <= status_byte;
    seen_length <= length_byte;
  end
endmodule

//--- gsb_status_bytes_test.sv
// self-checking testbench for the gateway status byte generator
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("Error %0t got %h exp %h", $time, a, b); end end
module gsb_status_bytes_test;
  import gsb_pkg::*;
  logic          sys_clk        = 1'b0;
  logic          reset          = 1'b1;
  logic [1:0]    service_switch = 2'h0;
  gsb_mode_type  gateway_mode   = MODE_TRANSPARENT;
  logic [7:0]    input_data_len = 8'h08;
  logic [10:0]   tx_buffer_fill = 11'h000;
  logic [10:0]   ring_fill      = 11'h000;
  gsb_event_type events         = '0;
  logic [15:0]   message_len    = 16'h0000;
  logic [7:0]    st, len, plc_st, plc_len;
  logic          led, rts, l0;
  gsb_event_type e;
  int            err_count      = 0;
  int            checks_done    = 0;

  always #4 sys_clk = ~sys_clk;

  gsb_status_bytes #(.FLASH_HALF_CYC(4)) dut (
    .sys_clk(sys_clk), .reset(reset), .service_switch(service_switch),
    .gateway_mode(gateway_mode), .input_data_len(input_data_len),
    .tx_buffer_fill(tx_buffer_fill), .ring_fill(ring_fill), .events(events),
    .message_len(message_len), .status_byte0_r(st), .payload_length_r(len),
    .power_led(led), .serial_rts_r(rts));

  gsb_plc_model plc (.sys_clk(sys_clk), .status_byte(st), .length_byte(len),
    .seen_status(plc_st), .seen_length(plc_len));

  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // one-cycle event pulse, then let the status bytes settle
  task automatic pulse(input gsb_event_type ev, input logic [15:0] ml);
    @(posedge sys_clk);
    events <= ev;
    message_len <= ml;
    @(posedge sys_clk);
    events <= '0;
    wait_n(5);
  endtask

  task automatic t_service;
    for (int p = 1; p < 3; p++) begin
      @(posedge sys_clk);
      service_switch <= 2'(p);
      wait_n(7);
      `CHK(plc_st, 8'h04)
      l0 = led;
      wait_n(4);
      `CHK(led, ~l0)
    end
    @(posedge sys_clk);
    service_switch <= 2'h0;
    wait_n(12);
    `CHK(plc_st, 8'h00)
    `CHK(led, 1'b1)
    // the unused switch code must not count as a service position
    @(posedge sys_clk);
    service_switch <= 2'h3;
    wait_n(12);
    `CHK(plc_st, 8'h00)
    `CHK(led, 1'b1)
    @(posedge sys_clk);
    service_switch <= 2'h0;
  endtask

  task automatic t_wack;
    e = '0;
    e.copy_done = 1'b1;
    pulse(e, 16'h0000);
    `CHK(plc_st, 8'h01)
    e = '0;
    e.send_done = 1'b1;
    pulse(e, 16'h0000);
    `CHK(plc_st, 8'h00)
    e = '0;
    e.copy_done = 1'b1;
    e.send_done = 1'b1;
    pulse(e, 16'h0000);
    `CHK(plc_st, 8'h01)
  endtask

  task automatic t_transparent;
    e = '0;
    e.set_sent = 1'b1;
    pulse(e, 16'h0014);
    `CHK(plc_st, 8'hA1)
    `CHK(plc_len, 8'h08)
    pulse(e, 16'h0005);
    `CHK(plc_st, 8'h21)
    `CHK(plc_len, 8'h05)
    e = '0;
    e.block_moved = 1'b1;
    pulse(e, 16'h0003);
    `CHK(plc_st, 8'h21)
    `CHK(plc_len, 8'h05)
  endtask

  task automatic t_collective;
    @(posedge sys_clk);
    gateway_mode <= MODE_COLLECTIVE;
    tx_buffer_fill <= 11'h010;
    wait_n(5);
    `CHK(plc_st, 8'h29)
    e = '0;
    e.block_moved = 1'b1;
    pulse(e, 16'h0006);
    `CHK(plc_st, 8'h39)
    `CHK(plc_len, 8'h06)
    e = '0;
    e.set_sent = 1'b1;
    pulse(e, 16'h0007);
    `CHK(plc_st, 8'h39)
    `CHK(plc_len, 8'h07)
    @(posedge sys_clk);
    tx_buffer_fill <= 11'h000;
    wait_n(5);
    `CHK(plc_st, 8'h31)
    @(posedge sys_clk);
    gateway_mode <= MODE_TRANSPARENT;
  endtask

  task automatic t_overflow;
    @(posedge sys_clk);
    ring_fill <= 11'h400;
    e = '0;
    e.ring_write = 1'b1;
    pulse(e, 16'h0000);
    `CHK(plc_st, 8'h71)
    `CHK(rts, 1'b0)
    @(posedge sys_clk);
    ring_fill <= 11'h3FF;
    wait_n(5);
    `CHK(plc_st, 8'h31)
    `CHK(rts, 1'b1)
  endtask

  task automatic t_loss_reset;
    @(posedge sys_clk);
    reset <= 1'b1;
    wait_n(3);
    @(posedge sys_clk);
    reset <= 1'b0;
    wait_n(2);
    `CHK(plc_st, 8'h00)
    `CHK(plc_len, 8'h00)
    e = '0;
    e.discard = 1'b1;
    pulse(e, 16'h0000);
    `CHK(plc_st, 8'h20)
    wait_n(10);
    `CHK(plc_st, 8'h20)
  endtask

  task automatic finish_test;
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    wait_n(2);
    `CHK(plc_st, 8'h00)
    `CHK(plc_len, 8'h00)
    `CHK(rts, 1'b1)
    t_service();
    t_wack();
    t_transparent();
    t_collective();
    t_overflow();
    t_loss_reset();
    finish_test();
  end

  // watchdog: the whole run needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    finish_test();
  end
endmodule
